// >>> tcc_core.sv
// Purpose: Timer core with free-running counter, three captures, five compares.
// Assumes: Pins are asynchronous and are synchronised before use.
// Notes: APB slave answers with zero wait states; pslverr on unmapped address.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tcc_core (
    input wire logic core_clk,           // 100 MHz clock
    input wire logic sys_rst,            // Async reset, active high
    input wire logic psel,               // APB select
    input wire logic penable,            // APB access phase
    input wire logic pwrite,             // APB direction
    input wire logic [7:0] paddr,        // APB byte address
    input wire logic [31:0] pwdata,      // APB write data
    output logic [31:0] prdata,          // APB read data
    output logic pready,                 // APB ready
    output logic pslverr,                // APB error
    input wire logic [7:0] port_in,      // Port pin levels
    output logic [7:0] port_out,         // Port pin drive levels
    output logic [7:0] port_oe,          // Port pin output enables
    output logic accum_in,               // Port bit seven to pulse accumulator
    output logic irq                     // Level interrupt request
);
    localparam int CW = tcc_pkg::CNT_W;
    localparam int NC = tcc_pkg::N_CAP;
    localparam int NO = tcc_pkg::N_CMP;
    localparam int NF = tcc_pkg::NFLAG;

    tcc_pkg::tcc_req_t req;
    logic [CW-1:0] cnt_q;
    logic [7:0] lo_buf_q;
    logic frz_q;
    logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [CW-1:0] cap_q [NC];
    logic [CW-1:0] cmp_q [NO];
    logic [2*NC-1:0] edge_q;
    tcc_pkg::tcc_act_t [NO-1:0] act_q;
    logic [4:0] c1mask_q, c1data_q;
    logic [7:0] port_q;
    logic pa7_oe_q;
    logic [NF-1:0] stat_q, ien_q;
    logic [NF-1:0] ev;
    logic [7:0] pin_q;
    logic wr_acc, rd_acc;
    logic hit;
    logic [31:0] rd_d;

    assign req = '{addr: paddr, wr: pwrite, wdata: pwdata};
    assign wr_acc = psel && penable && req.wr;
    assign rd_acc = psel && penable && !req.wr;

    // Free-running counter; no bus write reaches it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= tcc_pkg::CNT_RST;
        end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // Low half buffer, held for one cycle after a high-half read
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frz_q <= 1'b0;
            lo_buf_q <= 8'h00;
        end else begin
            frz_q <= rd_acc && (req.addr == tcc_pkg::A_CNT_HI);
            if (!(rd_acc && (req.addr == tcc_pkg::A_CNT_HI)) && !frz_q) begin
                lo_buf_q <= cnt_q[7:0];
            end else if (rd_acc && (req.addr == tcc_pkg::A_CNT_HI)) begin
                lo_buf_q <= cnt_q[7:0];
            end
        end
    end

    // Two-flop synchroniser plus a history stage for edge detection
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            pin_s3_q <= 8'h00;
        end else begin
            pin_s1_q <= port_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Capture channels on port bits zero to two
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_cap
            logic [1:0] sel;
            logic rise, fall;
            assign sel = edge_q[2*gi +: 2];
            assign rise = pin_s2_q[gi] && !pin_s3_q[gi];
            assign fall = !pin_s2_q[gi] && pin_s3_q[gi];
            assign ev[tcc_pkg::F_CAP+gi] = (rise && sel[0]) || (fall && sel[1]);
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cap_q[gi] <= tcc_pkg::CNT_RST;
                end else if (ev[tcc_pkg::F_CAP+gi]) begin
                    cap_q[gi] <= cnt_q;
                end
            end
        end
        // One dedicated comparator per compare channel, checked every cycle
        for (gi = 0; gi < NO; gi++) begin : g_cmp
            assign ev[tcc_pkg::F_CMP+gi] = (cmp_q[gi] == cnt_q);
        end
    endgenerate
    assign ev[tcc_pkg::F_OVF] = (cnt_q == tcc_pkg::CNT_MAX);

    // Register writes; compare registers reset to all ones so they idle quietly
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NO; i++) begin
                cmp_q[i] <= tcc_pkg::CNT_MAX;
            end
            edge_q <= '0;
            act_q <= '0;
            c1mask_q <= 5'h00;
            c1data_q <= 5'h00;
            port_q <= 8'h00;
            pa7_oe_q <= 1'b0;
            ien_q <= '0;
        end else if (wr_acc) begin
            for (int i = 0; i < NO; i++) begin
                if (req.addr == tcc_pkg::A_CMP0 + 8'(i) * tcc_pkg::A_STEP) begin
                    cmp_q[i] <= req.wdata[CW-1:0];
                end
            end
            case (req.addr)
                tcc_pkg::A_EDGE: edge_q <= req.wdata[2*NC-1:0];
                tcc_pkg::A_ACT: act_q <= req.wdata[2*NO-1:0];
                tcc_pkg::A_C1MASK: c1mask_q <= req.wdata[4:0];
                tcc_pkg::A_C1DATA: c1data_q <= req.wdata[4:0];
                tcc_pkg::A_PORT: port_q <= req.wdata[7:0];
                tcc_pkg::A_PCFG: pa7_oe_q <= req.wdata[0];
                tcc_pkg::A_IEN: ien_q <= req.wdata[NF-1:0];
                default: ;
            endcase
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= '0;
        end else begin
            if (wr_acc && req.addr == tcc_pkg::A_CLR) begin
                stat_q <= (stat_q & ~req.wdata[NF-1:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
        end
    end

    // Pin drive: channel one first, then dedicated channels override
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q <= 8'h00;
        end else begin
            for (int b = 3; b < 8; b++) begin
                if (ev[tcc_pkg::F_CMP] && c1mask_q[b-3]) begin
                    pin_q[b] <= c1data_q[b-3];
                end
            end
            for (int i = 1; i < NO; i++) begin
                if (ev[tcc_pkg::F_CMP+i] && act_q[i].en) begin
                    pin_q[7-i] <= act_q[i].lvl;
                end
            end
        end
    end

    // Port outputs: compare-owned pins ignore port data writes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_out <= 8'h00;
            port_oe <= 8'h00;
            accum_in <= 1'b0;
        end else begin
            port_out[2:0] <= 3'h0;
            port_oe[2:0] <= 3'h0;
            for (int b = 3; b < 7; b++) begin
                port_oe[b] <= 1'b1;
                port_out[b] <= (c1mask_q[b-3] || act_q[7-b].en) ? pin_q[b] : port_q[b];
            end
            port_oe[7] <= pa7_oe_q || c1mask_q[4];
            port_out[7] <= c1mask_q[4] ? pin_q[7] : port_q[7];
            accum_in <= pin_s2_q[7];
        end
    end

    // Read mux; unmapped addresses return zero with an error
    always_comb begin
        rd_d = 32'h0000_0000;
        hit = 1'b1;
        case (req.addr)
            tcc_pkg::A_CNT_HI: rd_d[7:0] = cnt_q[15:8];
            tcc_pkg::A_CNT_LO: rd_d[7:0] = frz_q ? lo_buf_q : cnt_q[7:0];
            tcc_pkg::A_EDGE: rd_d[2*NC-1:0] = edge_q;
            tcc_pkg::A_ACT: rd_d[2*NO-1:0] = act_q;
            tcc_pkg::A_C1MASK: rd_d[4:0] = c1mask_q;
            tcc_pkg::A_C1DATA: rd_d[4:0] = c1data_q;
            tcc_pkg::A_PORT: rd_d[7:0] = {pin_s2_q[7:3], pin_s2_q[2:0]};
            tcc_pkg::A_PCFG: rd_d[0] = pa7_oe_q;
            tcc_pkg::A_STAT: rd_d[NF-1:0] = stat_q;
            tcc_pkg::A_CLR: rd_d = 32'h0000_0000;
            tcc_pkg::A_IEN: rd_d[NF-1:0] = ien_q;
            default: begin
                hit = 1'b0;
                for (int i = 0; i < NC; i++) begin
                    if (req.addr == tcc_pkg::A_CAP0 + 8'(i) * tcc_pkg::A_STEP) begin
                        rd_d[CW-1:0] = cap_q[i];
                        hit = 1'b1;
                    end
                end
                for (int i = 0; i < NO; i++) begin
                    if (req.addr == tcc_pkg::A_CMP0 + 8'(i) * tcc_pkg::A_STEP) begin
                        rd_d[CW-1:0] = cmp_q[i];
                        hit = 1'b1;
                    end
                end
            end
        endcase
    end

    // APB answer registered in the setup cycle, so access completes at once
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= rd_d;
        end
    end

    // Interrupt level from enabled sticky flags
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & ien_q);
        end
    end
endmodule : tcc_core

// >>> tcc_pkg.sv
// Purpose: Constants and types for the timer capture/compare core.
// Assumes: APB with 32-bit data; one clock core_clk at 100 MHz.
// Notes: Register offsets are byte addresses, one aligned word each.
// Operation
// - One 16-bit free-running counter is the time base for everything.
// - Counter starts from zero after reset.
// - Selected capture edge copies counter into that channel's 16-bit register.
// - Five compare channels, each with own 16-bit register and comparator.
// - Every compare register is checked against the counter every cycle.
// - A match sets the channel flag and starts its automatic actions.
// - Match actions include interrupt request and output pin changes.
// - Software selects whether a match drives the pin high or low.
// - Compare channels two to five each own one port output pin.
// - Channel one may drive any chosen mix of port bits seven to three.
// - Port data writes do not move a pin owned by a compare channel.
// - Port bit seven is general I/O, accumulator input, or channel one output.
// - Counter wraps at maximum to zero, sets overflow flag; software cannot alter it.
// - Three independent capture channels on their own input pins.
// - Reading the high count half freezes the low half for one cycle.
// - Capture pin levels stay readable through the port data register.
package tcc_pkg;
    localparam int CNT_W = 16;
    localparam int N_CAP = 3;
    localparam int N_CMP = 5;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    // Byte offsets of the register words
    localparam logic [7:0] A_CNT_HI = 8'h00;   // Count high half, read freezes low
    localparam logic [7:0] A_CNT_LO = 8'h04;   // Count low half (buffered)
    localparam logic [7:0] A_CAP0 = 8'h08;     // Capture 0..2 at 08,0c,10
    localparam logic [7:0] A_CMP0 = 8'h14;     // Compare 1..5 at 14..24
    localparam logic [7:0] A_EDGE = 8'h28;     // Two edge bits per capture channel
    localparam logic [7:0] A_ACT = 8'h2c;      // Per compare: enable, level
    localparam logic [7:0] A_C1MASK = 8'h30;   // Channel one pin mask [4:0]
    localparam logic [7:0] A_C1DATA = 8'h34;   // Channel one pin levels [4:0]
    localparam logic [7:0] A_PORT = 8'h38;     // Port data register
    localparam logic [7:0] A_PCFG = 8'h3c;     // Bit 0: port bit seven output enable
    localparam logic [7:0] A_STAT = 8'h40;     // Sticky flags, read only
    localparam logic [7:0] A_CLR = 8'h44;      // Write one to clear flags
    localparam logic [7:0] A_IEN = 8'h48;      // Interrupt enables
    localparam logic [7:0] A_STEP = 8'h04;     // Word stride
    // Flag layout: [2:0] capture, [7:3] compare one..five, [8] overflow
    localparam int F_CAP = 0;
    localparam int F_CMP = 3;
    localparam int F_OVF = 8;
    localparam int NFLAG = 9;
    // Edge select encodings
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY = 2'h3;
    // Compare action: enable bit then level bit
    typedef struct packed {
        logic en;
        logic lvl;
    } tcc_act_t;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [31:0] wdata;
    } tcc_req_t;
endpackage : tcc_pkg

// >>> tcc_pin_model.sv
// Purpose: Pin model for the timer core: external drivers meet the core's drive.
// Assumes: A pin the core enables carries the core's level.
// Notes: Undriven pins take the external level, so inputs are never left floating.
`timescale 1ns/1ps
module tcc_pin_model (
    input wire logic [7:0] port_out, // Core drive levels
    input wire logic [7:0] port_oe,  // Core enables
    input wire logic [7:0] drv,      // External levels
    output logic [7:0] pins          // Resolved wires
);
    // Enabled core drive wins; capture pins stay readable
    assign pins = (port_oe & port_out) | (~port_oe & drv);
endmodule : tcc_pin_model

// >>> tcc_core_assertions.sv
// Purpose: Port checks for the timer capture/compare core.
// Assumes: One clock domain; APB writes land at the access edge.
// Notes: Interrupt enables are shadowed from APB writes.
`timescale 1ns/1ps
module tcc_core_assertions (
    input wire logic core_clk,       // Clock
    input wire logic sys_rst,        // Reset
    input wire logic psel,           // Select
    input wire logic penable,        // Enable
    input wire logic pwrite,         // Direction
    input wire logic [7:0] paddr,    // Address
    input wire logic [31:0] pwdata,  // Write data
    input wire logic [31:0] prdata,  // Read data
    input wire logic pready,         // Ready
    input wire logic pslverr,        // Error
    input wire logic [7:0] port_in,  // Pins
    input wire logic [7:0] port_out, // Drive
    input wire logic [7:0] port_oe,  // Enables
    input wire logic accum_in,       // Accumulator input
    input wire logic irq             // Interrupt
);
    logic [8:0] ien_q;
    logic wr_acc;
    // Only completed writes count, a held setup cycle must not
    assign wr_acc = psel && penable && pwrite && pready;
    // Shadow of the enable word
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ien_q <= 9'h000;
        end else if (wr_acc && paddr == tcc_pkg::A_IEN) begin
            ien_q <= pwdata[8:0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    oe_fixed_a: assert property (!$past(sys_rst) |-> port_oe[6:3] == 4'hf)
        else $error("compare pins not driven");
    cap_pins_a: assert property (port_oe[2:0] == 3'h0)
        else $error("capture pin driven");
    pcfg_oe_a: assert property (wr_acc && paddr == tcc_pkg::A_PCFG && pwdata[0] |-> ##[1:3] port_oe[7])
        else $error("bit seven output not enabled");
    accum_path_a: assert property ($rose(port_in[7]) |-> ##[1:4] accum_in)
        else $error("accumulator input lost");
    irq_gate_a: assert property (ien_q == 9'h0 && $past(ien_q) == 9'h0 |-> !irq)
        else $error("irq without enable");
    irq_src_a: assert property ($rose(irq) |-> $past(ien_q) != 9'h0)
        else $error("irq rose with no source enabled");
    pin_write_a: assert property (wr_acc && paddr == tcc_pkg::A_PORT |=> ##1 $stable(port_out[6:3]))
        else $error("port write moved compare pin");
    unmapped_a: assert property (psel && penable && pready && paddr > 8'h48 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    cover property ($rose(irq));
    cover property (pslverr);
    cover property ($rose(accum_in));
endmodule : tcc_core_assertions

// >>> tcc_core_tb.sv
// Purpose: Self-checking bench for the timer capture/compare core.
// Assumes: Zero wait APB; counter runs from zero at reset release.
// Notes: Overflow wait is a full counter lap, about 64k cycles.
`timescale 1ns/1ps
module tcc_core_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] pin_drv = 8'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, accum_in, irq, er;
    logic [7:0] port_in, port_out, port_oe;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    // Free clock, 100 MHz
    always #5 core_clk = ~core_clk;
    tcc_core i_tcc_core (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
        .accum_in(accum_in), .irq(irq));
    tcc_pin_model i_tcc_pin_model (.port_out(port_out), .port_oe(port_oe), .drv(pin_drv), .pins(port_in));
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; idles a cycle after so no signal is assigned twice at one edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Look at ready and data mid-cycle, where they are settled, then release at the edge
        @(negedge core_clk);
        while (pready !== 1'b1) @(negedge core_clk);
        rd = prdata;
        er = pslverr;
        @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wirq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
    endtask : wirq
    task automatic t_reset;
        pin_drv <= 8'h80;
        apb(tcc_pkg::A_STAT, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(tcc_pkg::A_CMP0, 1'b0, 32'h0);
        chk(rd, 32'h0000ffff);
        apb(8'h80, 1'b0, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(tcc_pkg::A_CNT_HI, 1'b1, 32'hffff);
        chk({31'h0, accum_in}, 32'h1);
    endtask : t_reset
    // Channel two drives high, then low on a later match; port writes must not move it
    task automatic t_compare;
        apb(tcc_pkg::A_IEN, 1'b1, 32'h10);
        apb(tcc_pkg::A_ACT, 1'b1, 32'h0c);
        apb(tcc_pkg::A_CMP0 + tcc_pkg::A_STEP, 1'b1, 32'h0200);
        wirq(600);
        chk({31'h0, port_out[6]}, 32'h1);
        apb(tcc_pkg::A_STAT, 1'b0, 32'h0);
        chk(rd & 32'h1ff, 32'h10);
        apb(tcc_pkg::A_PORT, 1'b1, 32'h0);
        chk({31'h0, port_out[6]}, 32'h1);
        apb(tcc_pkg::A_ACT, 1'b1, 32'h08);
        apb(tcc_pkg::A_CLR, 1'b1, 32'h1ff);
        apb(tcc_pkg::A_CMP0 + tcc_pkg::A_STEP, 1'b1, 32'h0300);
        wirq(600);
        chk({31'h0, port_out[6]}, 32'h0);
        apb(tcc_pkg::A_CLR, 1'b1, 32'h1ff);
    endtask : t_compare
    task automatic t_chan1;
        apb(tcc_pkg::A_PCFG, 1'b1, 32'h1);
        apb(tcc_pkg::A_C1MASK, 1'b1, 32'h10);
        apb(tcc_pkg::A_C1DATA, 1'b1, 32'h10);
        apb(tcc_pkg::A_ACT, 1'b1, 32'h02);
        apb(tcc_pkg::A_IEN, 1'b1, 32'h08);
        apb(tcc_pkg::A_CMP0, 1'b1, 32'h0400);
        wirq(600);
        chk({30'h0, port_oe[7], port_out[7]}, 32'h3);
        apb(tcc_pkg::A_CLR, 1'b1, 32'h1ff);
    endtask : t_chan1
    // Capture lands near 0x400 only if the counter began at zero and ignored the write
    task automatic t_capture;
        apb(tcc_pkg::A_EDGE, 1'b1, 32'h01);
        apb(tcc_pkg::A_IEN, 1'b1, 32'h01);
        pin_drv[0] <= 1'b1;
        wirq(20);
        apb(tcc_pkg::A_STAT, 1'b0, 32'h0);
        chk(rd & 32'h1ff, 32'h1);
        apb(tcc_pkg::A_CAP0, 1'b0, 32'h0);
        chk({31'h0, rd > 32'h400 && rd < 32'h500}, 32'h1);
        apb(tcc_pkg::A_PORT, 1'b0, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
    endtask : t_capture
    task automatic t_overflow;
        apb(tcc_pkg::A_CLR, 1'b1, 32'h1ff);
        apb(tcc_pkg::A_IEN, 1'b1, 32'h100);
        wirq(66000);
        apb(tcc_pkg::A_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[8]}, 32'h1);
    endtask : t_overflow
    // Hang guard, about a third above the overflow lap
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_compare();
        t_chan1();
        t_capture();
        t_overflow();
        end_of_test();
    end
endmodule : tcc_core_tb
bind tcc_core tcc_core_assertions i_tcc_core_assertions (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .accum_in(accum_in), .irq(irq));
